/* File: verilog/ddtc_top.sv */
// Dual transfer controller: general engine (index 0) and external engine (index 1)
//
// Contract
// - General engine moves data among all four memory regions, never a handshake device.
// - External engine serves handshake device only in single mode, paired with external side.
// - External engine dual transfers stay among external memory and mapped devices.
// - Single address transfer finishes in one bus cycle, device and memory together.
// - Dual address transfer is a source read followed by a destination write.
// - General engine has no address mode; always separate source and destination.
// - No cycle-steal or burst choice; interconnect arbitrates, engines run concurrently.
// - Engine may move data while the CPU uses ROM and RAM.
// - Both engines leave module stop after reset without software action.
// - One stop bit gates general engine and data transfer controller together.
// - External engine has its own independent stop bit.
// - Update field 00 keeps address fixed, 10 increments after each transfer.
// - Request source 01 starts channel on interrupt controller requests.
// - Transfer mode 00 is normal: one unit per request until count ends.
// - Size field 00 means 8-bit data units.
// - Activation flag bit 0 clears triggering request flag when transfer starts.
// - Transfer end flag clears automatically when channel transfer is enabled.
// - At count end set transfer end flag; request interrupt if enabled.
// - Transfers run only while module start and channel enable are both 1.
// - Peripheral trigger chosen by vector number in channel trigger select.
// - Count 0000h means free running; FFFFh is the largest finite count.
`timescale 1ns/100ps
`default_nettype none
`include "ddtc_cfg.svh"
module ddtc_top #(
  parameter int DATA_W = 32
) (
  // Clock and reset
  input  wire logic                    ref_clk,
  input  wire logic                    rst_n,
  // Module stop control word
  input  wire logic                    stop_write,
  input  wire logic [31:0]             stop_wdata,
  output logic [1:0]                   stop_status,
  output logic                         gen_clock_run,
  output logic                         dtc_clock_run,
  output logic                         ext_clock_run,
  // Channel settings, index 0 general, 1 external
  input  wire logic [1:0]              module_start_bit,
  input  wire logic [1:0]              channel_transfer_enable,
  input  wire logic [1:0][1:0]         source_update_field,
  input  wire logic [1:0][1:0]         destination_update_field,
  input  wire logic [1:0][1:0]         request_source_field,
  input  wire logic [1:0][1:0]         transfer_mode_field,
  input  wire logic [1:0][1:0]         data_unit_size_field,
  input  wire logic [1:0]              activation_flag_control_bit,
  input  wire logic [1:0]              transfer_end_irq_enable,
  input  wire logic [1:0][15:0]        transfer_count_reg,
  input  wire logic [1:0][31:0]        source_address,
  input  wire logic [1:0][31:0]        destination_address,
  input  wire logic [1:0][7:0]         channel_trigger_select,
  input  wire logic                    ext_single_mode,
  input  wire logic                    ext_single_to_device,
  // Requests
  input  wire logic [1:0]              software_request,
  input  wire logic                    periph_irq_valid,
  input  wire logic [7:0]              periph_irq_vector,
  // Status and events
  output logic [1:0]                   transfer_end_flag,
  output logic [1:0]                   route_error,
  output logic [1:0][15:0]             remaining_count,
  output logic [1:0]                   channel_busy,
  output logic [1:0]                   request_flag_clear,
  output logic [1:0]                   transfer_end_irq,
  // Bus master port per engine
  output logic [1:0]                   bus_req,
  output logic [1:0]                   bus_write,
  output logic [1:0][31:0]             bus_addr,
  output logic [1:0][1:0]              bus_size,
  output logic [1:0][DATA_W-1:0]       bus_wdata,
  input  wire logic [1:0][DATA_W-1:0]  bus_rdata,
  input  wire logic [1:0]              bus_ack,
  // Handshake device acknowledge
  output logic                         external_transfer_acknowledge
);
  ddtc_pkg::ddtc_state_t state      [2];
  ddtc_pkg::ddtc_state_t next_state [2];
  logic [31:0] cur_src      [2];
  logic [31:0] next_cur_src [2];
  logic [31:0] cur_dst      [2];
  logic [31:0] next_cur_dst [2];
  logic [15:0] remaining      [2];
  logic [15:0] next_remaining [2];
  logic [1:0]  free_run;
  logic [1:0]  next_free_run;
  logic [1:0]  done;
  logic [1:0]  next_done;
  logic [1:0]  pending;
  logic [1:0]  next_pending;
  logic [1:0]  en_prev;
  logic [1:0]  next_en_prev;
  logic [1:0]  end_flag;
  logic [1:0]  next_end_flag;
  logic [1:0]  route_err;
  logic [1:0]  next_route_err;
  logic [1:0]  flag_clear;
  logic [1:0]  next_flag_clear;
  logic [1:0]  end_irq;
  logic [1:0]  next_end_irq;
  logic [1:0]  stop;
  logic [1:0]  next_stop;

  logic [1:0]  active;
  logic [1:0]  req_hit;
  logic [1:0]  start;
  logic [1:0]  refuse;
  logic [1:0]  complete;
  logic [1:0]  last_unit;
  logic [1:0]  single_sel;
  logic [1:0]  route_good;
  logic [1:0]  en_rise;
  logic [1:0]  buf_in_valid;
  logic [1:0]  buf_in_ready;
  logic [1:0]  buf_out_valid;
  logic [1:0]  buf_out_ready;
  logic [DATA_W-1:0] buf_out_data [2];

  function automatic logic [31:0] unit_bytes(input logic [1:0] size);
    case (size)
      `DDTC_SIZE_8:  unit_bytes = 32'h0000_0001;
      `DDTC_SIZE_16: unit_bytes = 32'h0000_0002;
      `DDTC_SIZE_32: unit_bytes = 32'h0000_0004;
      default:       unit_bytes = 32'h0000_0001;
    endcase
  endfunction

  function automatic ddtc_pkg::ddtc_region_t region_of(input logic [31:0] a);
    region_of = ddtc_pkg::ddtc_region_t'(a[`DDTC_REGION_MSB:`DDTC_REGION_LSB]);
  endfunction

  function automatic logic is_external(input ddtc_pkg::ddtc_region_t r);
    is_external = (r == ddtc_pkg::ddtc_ext_mem) || (r == ddtc_pkg::ddtc_ext_device);
  endfunction

  // In single mode the caller passes the memory side region as both ends
  function automatic logic route_ok(input logic ext, input ddtc_pkg::ddtc_region_t s,
                                    input ddtc_pkg::ddtc_region_t d);
    if (!ext) begin
      route_ok = 1'b1;
    end else begin
      route_ok = is_external(s) && is_external(d);
    end
  endfunction

  // Module stop: one bit for general engine plus data transfer controller
  always_comb begin
    next_stop = stop;
    if (stop_write) begin
      next_stop = {stop_wdata[`DDTC_EXT_STOP_BIT], stop_wdata[`DDTC_GEN_STOP_BIT]};
    end
  end

  always_ff @(posedge ref_clk or negedge rst_n) begin
    if (!rst_n) begin
      stop <= `DDTC_STOP_RESET;
    end else begin
      stop <= next_stop;
    end
  end

  assign stop_status   = stop;
  assign gen_clock_run = ~stop[0];
  assign dtc_clock_run = ~stop[0];
  assign ext_clock_run = ~stop[1];

  // Per-engine decode; each engine has its own bus port so the interconnect
  // can let both run alongside the CPU on other slaves
  always_comb begin
    for (int e = 0; e < 2; e++) begin
      en_rise[e]    = channel_transfer_enable[e] & ~en_prev[e];
      active[e]     = module_start_bit[e] & channel_transfer_enable[e] & ~stop[e]
                      & ~done[e];
      single_sel[e] = (e == 1) && ext_single_mode;
      if (single_sel[e]) begin
        route_good[e] = route_ok(1'b1,
                          region_of(ext_single_to_device ? cur_src[e] : cur_dst[e]),
                          region_of(ext_single_to_device ? cur_src[e] : cur_dst[e]));
      end else begin
        route_good[e] = route_ok(e == 1, region_of(cur_src[e]), region_of(cur_dst[e]));
      end
      if (request_source_field[e] == `DDTC_REQ_PERIPH) begin
        req_hit[e] = periph_irq_valid
                     && (periph_irq_vector == channel_trigger_select[e]);
      end else begin
        req_hit[e] = software_request[e];
      end
      start[e]     = (state[e] == ddtc_pkg::ddtc_idle) && active[e] && pending[e]
                     && route_good[e] && (single_sel[e] || buf_in_ready[e]);
      refuse[e]    = (state[e] == ddtc_pkg::ddtc_idle) && active[e] && pending[e]
                     && !route_good[e];
      complete[e]  = bus_ack[e] && (((state[e] == ddtc_pkg::ddtc_write) && buf_out_valid[e])
                     || (state[e] == ddtc_pkg::ddtc_single));
      last_unit[e] = !free_run[e] && (remaining[e] == `DDTC_COUNT_ONE);
    end
  end

  // Bus side of each engine
  always_comb begin
    for (int e = 0; e < 2; e++) begin
      bus_req[e]       = (state[e] == ddtc_pkg::ddtc_read) || (state[e] == ddtc_pkg::ddtc_single)
                         || ((state[e] == ddtc_pkg::ddtc_write) && buf_out_valid[e]);
      bus_write[e]     = (state[e] == ddtc_pkg::ddtc_write)
                         || ((state[e] == ddtc_pkg::ddtc_single) && !ext_single_to_device);
      bus_addr[e]      = bus_write[e] ? cur_dst[e] : cur_src[e];
      bus_size[e]      = data_unit_size_field[e];
      bus_wdata[e]     = (state[e] == ddtc_pkg::ddtc_write) ? buf_out_data[e] : '0;
      buf_in_valid[e]  = (state[e] == ddtc_pkg::ddtc_read) && bus_ack[e];
      buf_out_ready[e] = (state[e] == ddtc_pkg::ddtc_write) && bus_ack[e];
    end
  end

  // Device strobe and memory cycle share the one bus cycle
  assign external_transfer_acknowledge = (state[1] == ddtc_pkg::ddtc_single);

  genvar g;
  generate
    for (g = 0; g < 2; g++) begin : gen_buf
      ddtc_buf #(
        .WIDTH (DATA_W),
        .DEPTH (2)
      ) u_buf (
        .ref_clk   (ref_clk),
        .rst_n     (rst_n),
        .in_valid  (buf_in_valid[g]),
        .in_ready  (buf_in_ready[g]),
        .in_data   (bus_rdata[g]),
        .out_valid (buf_out_valid[g]),
        .out_ready (buf_out_ready[g]),
        .out_data  (buf_out_data[g])
      );
    end
  endgenerate

  // Channel sequencing; modes other than normal run as normal transfer
  always_comb begin
    for (int e = 0; e < 2; e++) begin
      next_state[e]     = state[e];
      next_cur_src[e]   = cur_src[e];
      next_cur_dst[e]   = cur_dst[e];
      next_remaining[e] = remaining[e];
      next_free_run[e]  = free_run[e];
      next_en_prev[e]   = channel_transfer_enable[e];
      case (state[e])
        ddtc_pkg::ddtc_idle: begin
          if (start[e]) begin
            next_state[e] = single_sel[e] ? ddtc_pkg::ddtc_single : ddtc_pkg::ddtc_read;
          end
        end
        ddtc_pkg::ddtc_read: begin
          if (bus_ack[e]) begin
            next_state[e] = ddtc_pkg::ddtc_write;
          end
        end
        ddtc_pkg::ddtc_write: begin
          if (complete[e]) begin
            next_state[e] = ddtc_pkg::ddtc_idle;
          end
        end
        ddtc_pkg::ddtc_single: begin
          if (bus_ack[e]) begin
            next_state[e] = ddtc_pkg::ddtc_idle;
          end
        end
        default: next_state[e] = ddtc_pkg::ddtc_idle;
      endcase
      if (complete[e]) begin
        // Device side of a single transfer has no address to move
        if (source_update_field[e] == `DDTC_UPD_INC
            && (!single_sel[e] || ext_single_to_device)) begin
          next_cur_src[e] = cur_src[e] + unit_bytes(data_unit_size_field[e]);
        end
        if (destination_update_field[e] == `DDTC_UPD_INC
            && (!single_sel[e] || !ext_single_to_device)) begin
          next_cur_dst[e] = cur_dst[e] + unit_bytes(data_unit_size_field[e]);
        end
        if (!free_run[e]) begin
          next_remaining[e] = remaining[e] - `DDTC_COUNT_ONE;
        end
      end
      if (en_rise[e]) begin
        next_cur_src[e]   = source_address[e];
        next_cur_dst[e]   = destination_address[e];
        next_remaining[e] = transfer_count_reg[e];
        next_free_run[e]  = (transfer_count_reg[e] == `DDTC_COUNT_FREE);
      end
      // One unit per request; a request seen while inactive is dropped
      next_pending[e]    = active[e] && ((pending[e] && !start[e] && !refuse[e])
                           || req_hit[e]);
      next_done[e]       = (done[e] || (complete[e] && last_unit[e])) && !en_rise[e];
      // Set wins over the clear caused by enabling
      next_end_flag[e]   = (end_flag[e] && !en_rise[e])
                           || (complete[e] && last_unit[e]);
      next_end_irq[e]    = complete[e] && last_unit[e] && transfer_end_irq_enable[e];
      next_route_err[e]  = (route_err[e] && !en_rise[e]) || refuse[e];
      next_flag_clear[e] = start[e] && (request_source_field[e] == `DDTC_REQ_PERIPH)
                           && (activation_flag_control_bit[e] == `DDTC_FLAG_CLEAR_AT_START);
    end
  end

  always_ff @(posedge ref_clk or negedge rst_n) begin
    if (!rst_n) begin
      for (int e = 0; e < 2; e++) begin
        state[e]     <= ddtc_pkg::ddtc_idle;
        cur_src[e]   <= 32'h0000_0000;
        cur_dst[e]   <= 32'h0000_0000;
        remaining[e] <= 16'h0000;
      end
      free_run   <= 2'b00;
      done       <= 2'b00;
      pending    <= 2'b00;
      en_prev    <= 2'b00;
      end_flag   <= 2'b00;
      end_irq    <= 2'b00;
      route_err  <= 2'b00;
      flag_clear <= 2'b00;
    end else begin
      state      <= next_state;
      cur_src    <= next_cur_src;
      cur_dst    <= next_cur_dst;
      remaining  <= next_remaining;
      free_run   <= next_free_run;
      done       <= next_done;
      pending    <= next_pending;
      en_prev    <= next_en_prev;
      end_flag   <= next_end_flag;
      end_irq    <= next_end_irq;
      route_err  <= next_route_err;
      flag_clear <= next_flag_clear;
    end
  end

  always_comb begin
    for (int e = 0; e < 2; e++) begin
      remaining_count[e] = remaining[e];
      channel_busy[e]    = (state[e] != ddtc_pkg::ddtc_idle);
    end
  end
  assign transfer_end_flag  = end_flag;
  assign transfer_end_irq   = end_irq;
  assign route_error        = route_err;
  assign request_flag_clear = flag_clear;

  property p_dual_read_then_write;
    @(posedge ref_clk) disable iff (!rst_n)
      (state[0] == ddtc_pkg::ddtc_read) && bus_ack[0]
      |=> (state[0] == ddtc_pkg::ddtc_write) && bus_req[0] && bus_write[0];
  endproperty
  a_dual_read_then_write: assert property (p_dual_read_then_write)
    else $error("read cycle not followed by write cycle");

  property p_single_one_cycle;
    @(posedge ref_clk) disable iff (!rst_n)
      external_transfer_acknowledge && bus_ack[1]
      |-> bus_req[1] ##1 (state[1] == ddtc_pkg::ddtc_idle) && !external_transfer_acknowledge;
  endproperty
  a_single_one_cycle: assert property (p_single_one_cycle)
    else $error("single transfer took more than one bus cycle");

  property p_ext_offchip_only;
    @(posedge ref_clk) disable iff (!rst_n)
      bus_req[1] |-> bus_addr[1][`DDTC_REGION_MSB];
  endproperty
  a_ext_offchip_only: assert property (p_ext_offchip_only)
    else $error("external engine addressed an on-chip region");

  property p_general_never_single;
    @(posedge ref_clk) disable iff (!rst_n)
      $rose(bus_req[0]) && !bus_write[0] |-> (state[0] == ddtc_pkg::ddtc_read);
  endproperty
  a_general_never_single: assert property (p_general_never_single)
    else $error("general engine did not start with a source read");

  property p_end_flag_set;
    @(posedge ref_clk) disable iff (!rst_n)
      complete[0] && last_unit[0] |=> transfer_end_flag[0] && !channel_busy[0];
  endproperty
  a_end_flag_set: assert property (p_end_flag_set)
    else $error("transfer end flag not set at count end");

  property p_end_irq_gate;
    @(posedge ref_clk) disable iff (!rst_n)
      transfer_end_irq[0] |-> transfer_end_flag[0] && $past(transfer_end_irq_enable[0]);
  endproperty
  a_end_irq_gate: assert property (p_end_irq_gate)
    else $error("transfer end interrupt without flag or enable");

  property p_flag_clear_on_enable;
    @(posedge ref_clk) disable iff (!rst_n)
      $rose(channel_transfer_enable[0]) && !(complete[0] && last_unit[0])
      |=> !transfer_end_flag[0];
  endproperty
  a_flag_clear_on_enable: assert property (p_flag_clear_on_enable)
    else $error("transfer end flag survived channel enable");

  property p_request_flag_clear;
    @(posedge ref_clk) disable iff (!rst_n)
      request_flag_clear[0] |-> !$past(activation_flag_control_bit[0])
                                && $past(state[0] == ddtc_pkg::ddtc_idle) && channel_busy[0];
  endproperty
  a_request_flag_clear: assert property (p_request_flag_clear)
    else $error("request flag cleared without a start");

  property p_stop_shared;
    @(posedge ref_clk) disable iff (!rst_n)
      stop_write |=> (gen_clock_run == !$past(stop_wdata[`DDTC_GEN_STOP_BIT]))
                     && (dtc_clock_run == gen_clock_run);
  endproperty
  a_stop_shared: assert property (p_stop_shared)
    else $error("general engine and transfer controller stop differ");

  property p_ext_stop_own;
    @(posedge ref_clk) disable iff (!rst_n)
      stop_write |=> ext_clock_run == !$past(stop_wdata[`DDTC_EXT_STOP_BIT]);
  endproperty
  a_ext_stop_own: assert property (p_ext_stop_own)
    else $error("external engine stop bit not applied");

  property p_ignore_when_off;
    @(posedge ref_clk) disable iff (!rst_n)
      ((state[0] == ddtc_pkg::ddtc_idle) && !module_start_bit[0]) [*2]
      |=> (state[0] == ddtc_pkg::ddtc_idle) && !request_flag_clear[0];
  endproperty
  a_ignore_when_off: assert property (p_ignore_when_off)
    else $error("transfer started while module start bit was 0");
endmodule
`default_nettype wire

/* File: verilog/ddtc_cfg.svh */
// Field encodings, bit positions and reset values of the dual transfer controller
`ifndef DDTC_CFG_SVH
`define DDTC_CFG_SVH

// Address update field encodings
`define DDTC_UPD_FIXED     2'b00
`define DDTC_UPD_INC       2'b10

// Request source field encodings
`define DDTC_REQ_SOFTWARE  2'b00
`define DDTC_REQ_PERIPH    2'b01

// Transfer mode field encodings
`define DDTC_MODE_NORMAL   2'b00

// Data unit size field encodings
`define DDTC_SIZE_8        2'b00
`define DDTC_SIZE_16       2'b01
`define DDTC_SIZE_32       2'b10

// Activation flag control: 0 clears the triggering request flag at start
`define DDTC_FLAG_CLEAR_AT_START 1'b0

// Transfer count meaning free running, and the count of one unit
`define DDTC_COUNT_FREE    16'h0000
`define DDTC_COUNT_ONE     16'h0001

// Bit positions in the module stop control word
`define DDTC_GEN_STOP_BIT  28
`define DDTC_EXT_STOP_BIT  29

// Both engines leave module stop after reset
`define DDTC_STOP_RESET    2'b00

// Address bits that select the region
`define DDTC_REGION_MSB    31
`define DDTC_REGION_LSB    30

`endif

/* File: verilog/ddtc_pkg.sv */
// Types shared by the dual transfer controller
`default_nettype none
package ddtc_pkg;

  typedef enum logic [1:0] {
    ddtc_idle   = 2'b00,
    ddtc_read   = 2'b01,
    ddtc_write  = 2'b10,
    ddtc_single = 2'b11
  } ddtc_state_t;

  typedef enum logic [1:0] {
    ddtc_onchip_mem    = 2'b00,
    ddtc_onchip_periph = 2'b01,
    ddtc_ext_mem       = 2'b10,
    ddtc_ext_device    = 2'b11
  } ddtc_region_t;

endpackage
`default_nettype wire

/* File: verilog/ddtc_buf.sv */
// Two-entry data buffer between the read and the write bus cycle
`timescale 1ns/100ps
`default_nettype none
module ddtc_buf #(
  parameter int WIDTH = 32,
  parameter int DEPTH = 2
) (
  // Clock and reset
  input  wire logic             ref_clk,
  input  wire logic             rst_n,
  // Fill side
  input  wire logic             in_valid,
  output logic                  in_ready,
  input  wire logic [WIDTH-1:0] in_data,
  // Drain side
  output logic                  out_valid,
  input  wire logic             out_ready,
  output logic [WIDTH-1:0]      out_data
);
  localparam int PW = (DEPTH > 1) ? $clog2(DEPTH) : 1;
  localparam int CW = $clog2(DEPTH + 1);

  logic [WIDTH-1:0] mem      [DEPTH];
  logic [WIDTH-1:0] next_mem [DEPTH];
  logic [PW-1:0]    wr_ptr;
  logic [PW-1:0]    next_wr_ptr;
  logic [PW-1:0]    rd_ptr;
  logic [PW-1:0]    next_rd_ptr;
  logic [CW-1:0]    count;
  logic [CW-1:0]    next_count;
  logic             push;
  logic             pop;

  function automatic logic [PW-1:0] wrap_inc(input logic [PW-1:0] p);
    wrap_inc = (p == PW'(DEPTH - 1)) ? '0 : p + PW'(1);
  endfunction

  assign in_ready  = (count != CW'(DEPTH));
  assign out_valid = (count != '0);
  assign out_data  = mem[rd_ptr];

  always_comb begin
    push        = in_valid & in_ready;
    pop         = out_valid & out_ready;
    next_mem    = mem;
    next_wr_ptr = wr_ptr;
    next_rd_ptr = rd_ptr;
    next_count  = count;
    if (push) begin
      next_mem[wr_ptr] = in_data;
      next_wr_ptr      = wrap_inc(wr_ptr);
    end
    if (pop) begin
      next_rd_ptr = wrap_inc(rd_ptr);
    end
    case ({push, pop})
      2'b10:   next_count = count + CW'(1);
      2'b01:   next_count = count - CW'(1);
      default: next_count = count;
    endcase
  end

  always_ff @(posedge ref_clk or negedge rst_n) begin
    if (!rst_n) begin
      for (int i = 0; i < DEPTH; i++) begin
        mem[i] <= '0;
      end
      wr_ptr <= '0;
      rd_ptr <= '0;
      count  <= '0;
    end else begin
      mem    <= next_mem;
      wr_ptr <= next_wr_ptr;
      rd_ptr <= next_rd_ptr;
      count  <= next_count;
    end
  end
endmodule
`default_nettype wire

/* File: tb/ddtc_slave_model.sv */
// Bus slave model that answers one engine after a fixed wait
`timescale 1ns/100ps
`default_nettype none
module ddtc_slave_model #(
  parameter int DLY = 0
) (
  // Clock and reset
  input  wire logic        ref_clk,
  input  wire logic        rst_n,
  // Engine bus
  input  wire logic        bus_req,
  input  wire logic [31:0] bus_addr,
  output logic             bus_ack,
  output logic [31:0]      bus_rdata
);
  int cnt;
  // One-cycle acknowledge; different slaves answer on their own
  always @(posedge ref_clk or negedge rst_n) begin
    if (!rst_n) begin
      cnt <= 0;
      bus_ack <= 1'b0;
    end else begin
      bus_ack <= bus_req && !bus_ack && cnt == DLY;
      cnt <= (bus_req && !bus_ack && cnt < DLY) ? cnt + 1 : 0;
    end
  end
  // Read data only valid with the acknowledge; a toggling pattern otherwise
  assign bus_rdata = bus_ack ? ~bus_addr : 32'h5A5A5A5A ^ {32{ref_clk}};
endmodule
`default_nettype wire

/* File: tb/ddtc_top_tb_top.sv */
// Testbench for the dual transfer controller
`timescale 1ns/100ps
`default_nettype none
module ddtc_top_tb_top;
  logic ref_clk = 1'b0, rst_n = 1'b0, stop_write = 1'b0, ext_single_mode = 1'b0;
  logic ext_single_to_device = 1'b0, periph_irq_valid = 1'b0, external_transfer_acknowledge;
  logic gen_clock_run, dtc_clock_run, ext_clock_run;
  logic [31:0] stop_wdata = '0;
  logic [7:0] periph_irq_vector = '0;
  logic [1:0] module_start_bit = '0, channel_transfer_enable = '0, software_request = '0;
  logic [1:0] activation_flag_control_bit = '0, transfer_end_irq_enable = '0, stop_status;
  logic [1:0] transfer_end_flag, route_error, channel_busy, request_flag_clear;
  logic [1:0] transfer_end_irq, bus_req, bus_write;
  wire logic [1:0] bus_ack;
  logic [1:0][1:0] source_update_field = '0, destination_update_field = '0, bus_size;
  logic [1:0][1:0] request_source_field = '0, transfer_mode_field = '0, data_unit_size_field = '0;
  logic [1:0][15:0] transfer_count_reg = '0, remaining_count;
  logic [1:0][31:0] source_address = '0, destination_address = '0, bus_addr, bus_wdata;
  wire logic [1:0][31:0] bus_rdata;
  logic [1:0][7:0] channel_trigger_select = '0;
  logic [65:0] log_q[2][$];
  int miscompares = 0, total_checks = 0, clr_cnt = 0, irq_cnt = 0;

  ddtc_top i_dut (.*);
  ddtc_slave_model #(.DLY(0)) i_fast (.ref_clk, .rst_n, .bus_req(bus_req[0]),
    .bus_addr(bus_addr[0]), .bus_ack(bus_ack[0]), .bus_rdata(bus_rdata[0]));
  ddtc_slave_model #(.DLY(3)) i_slow (.ref_clk, .rst_n, .bus_req(bus_req[1]),
    .bus_addr(bus_addr[1]), .bus_ack(bus_ack[1]), .bus_rdata(bus_rdata[1]));

  initial begin
    forever #10 ref_clk = ~ref_clk;
  end
  // Completed bus cycles and one-cycle pulses are logged at the sampling edge
  always @(posedge ref_clk) begin
    for (int e = 0; e < 2; e++)
      if (bus_req[e] && bus_ack[e])
        log_q[e].push_back({external_transfer_acknowledge, bus_write[e], bus_addr[e],
                            bus_wdata[e]});
    clr_cnt += request_flag_clear[0];
    irq_cnt += transfer_end_irq[0];
  end

  task automatic check(input logic [65:0] got, input logic [65:0] exp);
    total_checks++;
    if (got !== exp) begin
      miscompares++;
      $display("unexpected %0t got %h exp %h", $time, got, exp);
    end
  endtask
  task automatic want(input int e, input logic [65:0] exp);
    logic [65:0] got;
    got = 'x;
    if (log_q[e].size() > 0) got = log_q[e].pop_front();
    check(got, exp);
  endtask
  task automatic stop(input logic [31:0] w);
    stop_wdata = w;
    stop_write = 1'b1;
    @(negedge ref_clk);
    stop_write = 1'b0;
    @(negedge ref_clk);
  endtask
  // A fresh enable rise loads addresses and count
  task automatic arm(input int ch);
    channel_transfer_enable[ch] = 1'b0;
    @(negedge ref_clk);
    channel_transfer_enable[ch] = 1'b1;
    @(negedge ref_clk);
  endtask
  task automatic go(input int ch, input logic p, input logic [7:0] v);
    int i;
    software_request[ch] = !p;
    periph_irq_valid = p;
    periph_irq_vector = v;
    @(negedge ref_clk);
    software_request = '0;
    periph_irq_valid = 1'b0;
    for (i = 0; i < 3 || (channel_busy !== 2'b00 && i < 80); i++) @(negedge ref_clk);
  endtask
  task automatic test_done;
    $display("checks %0d miscompares %0d", total_checks, miscompares);
    if (miscompares == 0 && total_checks > 0)
      $display("Regression OK");
    else
      $display("Regression broken");
    $finish;
  endtask

  initial begin
    repeat (5) @(negedge ref_clk);
    rst_n = 1'b1;
    check({stop_status, gen_clock_run, dtc_clock_run, ext_clock_run}, 5'b00111);
    stop(32'h1000_0000);
    check({stop_status, gen_clock_run, dtc_clock_run, ext_clock_run}, 5'b01001);
    source_address[0] = 32'h4000_0010;
    destination_address[0] = 32'h0000_0100;
    destination_update_field[0] = 2'b10;
    transfer_count_reg[0] = 16'h0002;
    transfer_end_irq_enable[0] = 1'b1;
    module_start_bit = 2'b11;
    arm(0);
    go(0, 1'b0, 8'h00);
    stop(32'h2000_0000);
    check({stop_status, gen_clock_run, dtc_clock_run, ext_clock_run}, 5'b10110);
    stop(32'h0);
    check(log_q[0].size(), 0);
    go(0, 1'b0, 8'h00);
    go(0, 1'b0, 8'h00);
    go(0, 1'b0, 8'h00);
    for (int u = 0; u < 2; u++) begin
      want(0, {2'b00, 32'h4000_0010, 32'h0});
      want(0, {2'b01, 32'h0000_0100 + u, ~32'h4000_0010});
    end
    check(log_q[0].size(), 0);
    check({transfer_end_flag[0], 8'(irq_cnt), 8'(clr_cnt), remaining_count[0]},
          {1'b1, 8'h01, 8'h00, 16'h0000});
    request_source_field[0] = 2'b01;
    channel_trigger_select[0] = 8'd100;
    transfer_count_reg[0] = 16'h0001;
    arm(0);
    check(transfer_end_flag[0], 0);
    go(0, 1'b1, 8'd99);
    check(log_q[0].size(), 0);
    go(0, 1'b1, 8'd100);
    want(0, {2'b00, 32'h4000_0010, 32'h0});
    want(0, {2'b01, 32'h0000_0100, ~32'h4000_0010});
    check(clr_cnt, 1);
    module_start_bit[0] = 1'b0;
    arm(0);
    go(0, 1'b1, 8'd100);
    check(log_q[0].size(), 0);
    source_address[1] = 32'h8000_0000;
    destination_address[1] = 32'hC000_0000;
    data_unit_size_field[1] = 2'b10;
    arm(1);
    go(1, 1'b0, 8'h00);
    go(1, 1'b0, 8'h00);
    for (int u = 0; u < 2; u++) begin
      want(1, {2'b00, 32'h8000_0000, 32'h0});
      want(1, {2'b01, 32'hC000_0000, ~32'h8000_0000});
    end
    check(transfer_end_flag[1], 0);
    ext_single_mode = 1'b1;
    ext_single_to_device = 1'b1;
    go(1, 1'b0, 8'h00);
    want(1, {2'b10, 32'h8000_0000, 32'h0});
    check(bus_size, 4'h8);
    ext_single_mode = 1'b0;
    source_address[1] = 32'h0000_0000;
    arm(1);
    go(1, 1'b0, 8'h00);
    check({route_error[1], 32'(log_q[1].size())}, {1'b1, 32'h0});
    test_done;
  end

  initial begin
    repeat (5000) @(posedge ref_clk);
    miscompares++;
    test_done;
  end
endmodule
`default_nettype wire
